// File: pscf_cell_model.sv
/* backup cell measurement unit; answers a start with one done pulse after DELAY cycles, a start during the count restarting it */
`timescale 1ns/1ps
module pscf_cell_model #(
	parameter int DELAY = 4
) (
	// measurement handshake
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic [1:0] level,
	output logic            done,
	output logic      [1:0] result
);
	int cnt = 0;
	always @(posedge clk) begin
		done <= cnt == 1;
		result <= (cnt == 1) ? level : ~level;
		if (go)
			cnt <= DELAY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule : pscf_cell_model

// File: pscf_flag_capture.sv
/*
 * restore flag capture: tracks which rails stayed enabled through suspend and
 * publishes them at the wake from suspend; assumes one-cycle wake pulses
 */
`timescale 1ns/1ps
`include "pscf_params.svh"
module pscf_flag_capture (
	// clock and reset
	input wire logic      clk,
	input wire logic      rst_sync_n,
	// carrier
	pscf_flag_if.capture  fl
);
	logic [7:0] seen_q;
	logic [7:0] seen_d;
	logic [7:0] flags_q;
	logic [7:0] flags_d;

	always_comb begin
		seen_d  = seen_q;
		flags_d = flags_q;
		if (fl.wake_from_suspend) begin
			flags_d = seen_q & fl.rails_on;
			seen_d  = 8'hFF;
		end else if (fl.wake_from_off) begin
			flags_d = 8'h00;
			seen_d  = 8'hFF;
		end else begin
			seen_d = seen_q & fl.rails_on;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			seen_q  <= 8'hFF;
			flags_q <= `PSCF_FLAG_RESET;
		end else begin
			seen_q  <= seen_d;
			flags_q <= flags_d;
		end
	end

	assign fl.flags = flags_q;
endmodule : pscf_flag_capture

// File: pscf_flag_if.sv
/*
 * carrier between the register bank and the suspend restore flag capture;
 * assumes both ends share clk and the synchronised reset
 */
`timescale 1ns/1ps
interface pscf_flag_if;
	logic [7:0] rails_on;
	logic       wake_from_suspend;
	logic       wake_from_off;
	logic [7:0] flags;

	modport bank (output rails_on, output wake_from_suspend, output wake_from_off, input flags);
	modport capture (input rails_on, input wake_from_suspend, input wake_from_off, output flags);
endinterface : pscf_flag_if

// File: pscf_params.svh
/*
 * offsets, field positions, reset values and sequencer state codes of the status, control and
 * restore-flag registers; assumes an 8-bit register space addressed by subaddress
 */
`ifndef PSCF_PARAMS_SVH
`define PSCF_PARAMS_SVH

`define PSCF_STATUS_ADDR      8'h05
`define PSCF_CONTROL_ADDR     8'h06
`define PSCF_FLAG_ADDR        8'h07

`define PSCF_CONTROL_RESET    8'h00
`define PSCF_FLAG_RESET       8'h00
`define PSCF_STATUS_RESET_HI  2'h0

`define PSCF_ST_SEAL_BIT      7
`define PSCF_ST_NVM_BIT       6
`define PSCF_ST_ADAPTER_BIT   5
`define PSCF_ST_BUTTON_BIT    4
`define PSCF_CTL_PF_BIT       1
`define PSCF_CTL_MEAS_BIT     0

`define PSCF_SEQ_TRANSITION   2'h0
`define PSCF_SEQ_WAIT_EN      2'h1
`define PSCF_SEQ_ACTIVE       2'h2
`define PSCF_SEQ_SUSPEND      2'h3

`endif

// File: pscf_pkg.sv
/*
 * types shared by the register bank and its testbench;
 * assumes the constants header is included by the files that need numbers
 */
package pscf_pkg;
	typedef enum logic [1:0] {
		PSCF_SEQ_TRANSITIONAL,
		PSCF_SEQ_WAIT_POWER_ENABLE,
		PSCF_SEQ_ACTIVE,
		PSCF_SEQ_SUSPEND
	} pscf_seq_t;

	typedef enum logic [1:0] {
		PSCF_MEAS_IDLE,
		PSCF_MEAS_BUSY
	} pscf_meas_t;
endpackage : pscf_pkg

// File: pscf_regs.sv
/*
 * status, control and suspend restore flag registers of the power manager;
 * assumes a register port from the serial interface giving a one-cycle
 * write strobe and a combinational read by subaddress, and live pin inputs
 */
`timescale 1ns/1ps
`include "pscf_params.svh"
module pscf_regs (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic             reg_wr,
	input  wire logic [7:0]       reg_wdata,
	output logic      [7:0]       reg_rdata,
	// pins
	input  wire logic             adapter_detect_pin,
	input  wire logic             push_button_pin,
	input  wire logic             powerfail_output_n,
	// device state
	input  wire logic             seal_broken,
	input  wire logic             nvm_differs,
	input  wire pscf_pkg::pscf_seq_t seq_state,
	input  wire logic [7:0]       rails_on,
	input  wire logic             wake_from_suspend,
	input  wire logic             wake_from_off,
	// backup cell measurement
	output logic                  backup_cell_measure_go,
	input  wire logic             backup_cell_measure_done,
	input  wire logic [1:0]       backup_cell_result,
	// shutdown request to the sequencer
	output logic                  powerfail_shutdown
);
	logic       rst_s1_q;
	logic       rst_s1_d;
	logic       rst_sync_n;
	logic       rst_sync_d;
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s1_d;
	logic [2:0] pin_s2_q;
	logic [2:0] pin_s2_d;

	// reset asserts at once and lets go two edges later
	always_comb begin
		rst_s1_d   = 1'b1;
		rst_sync_d = rst_s1_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_q   <= rst_s1_d;
			rst_sync_n <= rst_sync_d;
		end
	end

	// pins idle high; only the second stage feeds any logic
	always_comb begin
		pin_s1_d = {powerfail_output_n, push_button_pin, adapter_detect_pin};
		pin_s2_d = pin_s1_q;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_s1_q <= 3'h7;
			pin_s2_q <= 3'h7;
		end else begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
		end
	end

	// registers
	logic                  pf_en_q;
	logic                  pf_en_d;
	logic                  meas_bit_q;
	logic                  meas_bit_d;
	pscf_pkg::pscf_meas_t  meas_q;
	pscf_pkg::pscf_meas_t  meas_d;
	logic [1:0]            cell_q;
	logic [1:0]            cell_d;
	logic [1:0]            st_hi_q;
	logic [1:0]            st_hi_d;
	logic [3:0]            st_lo_q;
	logic [3:0]            st_lo_d;
	logic                  pf_off_q;
	logic                  pf_off_d;
	logic                  go_q;
	logic                  go_d;
	logic                  ctl_wr;

	pscf_flag_if fl ();

	assign fl.rails_on          = rails_on;
	assign fl.wake_from_suspend = wake_from_suspend;
	assign fl.wake_from_off     = wake_from_off;

	pscf_flag_capture u_flags (
		.clk        (clk),
		.rst_sync_n (rst_sync_n),
		.fl         (fl)
	);

	assign ctl_wr = reg_wr && (reg_addr == `PSCF_CONTROL_ADDR);

	always_comb begin
		pf_en_d    = pf_en_q;
		meas_bit_d = meas_bit_q;
		meas_d     = meas_q;
		cell_d     = cell_q;
		go_d       = 1'b0;
		st_hi_d    = {seal_broken, nvm_differs};
		st_lo_d[3] = ~pin_s2_q[0];
		st_lo_d[2] = ~pin_s2_q[1];
		st_lo_d[1:0] = seq_state;
		if (ctl_wr) begin
			pf_en_d = reg_wdata[`PSCF_CTL_PF_BIT];
		end
		case (meas_q)
			pscf_pkg::PSCF_MEAS_IDLE: begin
				if (ctl_wr && reg_wdata[`PSCF_CTL_MEAS_BIT]) begin
					meas_bit_d = 1'b1;
					go_d       = 1'b1;
					meas_d     = pscf_pkg::PSCF_MEAS_BUSY;
				end
			end
			pscf_pkg::PSCF_MEAS_BUSY: begin
				if (backup_cell_measure_done) begin
					meas_bit_d = 1'b0;
					cell_d     = backup_cell_result;
					meas_d     = pscf_pkg::PSCF_MEAS_IDLE;
				end
			end
			default: begin
				meas_d = pscf_pkg::PSCF_MEAS_IDLE;
			end
		endcase
		pf_off_d = pf_en_q && !pin_s2_q[2];
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pf_en_q    <= 1'b0;
			meas_bit_q <= 1'b0;
			meas_q     <= pscf_pkg::PSCF_MEAS_IDLE;
			cell_q     <= 2'h0;
			st_hi_q    <= `PSCF_STATUS_RESET_HI;
			st_lo_q    <= 4'h0;
			pf_off_q   <= 1'b0;
			go_q       <= 1'b0;
		end else begin
			pf_en_q    <= pf_en_d;
			meas_bit_q <= meas_bit_d;
			meas_q     <= meas_d;
			cell_q     <= cell_d;
			st_hi_q    <= st_hi_d;
			st_lo_q    <= st_lo_d;
			pf_off_q   <= pf_off_d;
			go_q       <= go_d;
		end
	end

	assign backup_cell_measure_go = go_q;
	assign powerfail_shutdown     = pf_off_q;

	logic [7:0] status_word;

	// status fields placed at their bit positions
	always_comb begin
		status_word                       = 8'h00;
		status_word[`PSCF_ST_SEAL_BIT]    = st_hi_q[1];
		status_word[`PSCF_ST_NVM_BIT]     = st_hi_q[0];
		status_word[`PSCF_ST_ADAPTER_BIT] = st_lo_q[3];
		status_word[`PSCF_ST_BUTTON_BIT]  = st_lo_q[2];
		status_word[3:2]                  = st_lo_q[1:0];
		status_word[1:0]                  = cell_q;
	end

	always_comb begin
		if (reg_addr == `PSCF_STATUS_ADDR) begin
			reg_rdata = status_word;
		end else if (reg_addr == `PSCF_CONTROL_ADDR) begin
			reg_rdata = {6'h00, pf_en_q, meas_bit_q};
		end else if (reg_addr == `PSCF_FLAG_ADDR) begin
			reg_rdata = fl.flags;
		end else begin
			reg_rdata = 8'h00;
		end
	end
endmodule : pscf_regs

// File: pscf_regs_assertions.sv
/* port checks of the status, control and flag bank; assumes the bind below and one clock */
`timescale 1ns/1ps
module pscf_regs_assertions (
	// observed ports
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       adapter_detect_pin,
	input wire logic       push_button_pin,
	input wire logic       seal_broken,
	input wire logic       wake_from_off,
	input wire logic       backup_cell_measure_go,
	input wire logic       powerfail_shutdown
);
	logic [2:0] up_q;
	// waits out the reset and pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	logic go_wr_q;
	// a write of one to the measurement start bit, one edge late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			go_wr_q <= 1'b0;
		else
			go_wr_q <= reg_wr && reg_addr == 8'h06 && reg_wdata[0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || up_q != 3'h7);
	a_go_pulse: assert property (backup_cell_measure_go |=> !backup_cell_measure_go) else $error("go too long");
	a_go_cause: assert property (backup_cell_measure_go |-> go_wr_q) else $error("go without write");
	a_ctl_resv: assert property (reg_addr == 8'h06 |-> reg_rdata[7:2] == 6'h00) else $error("reserved set");
	a_seal_bit: assert property (reg_addr == 8'h05 && $stable(seal_broken) |-> reg_rdata[7] == seal_broken)
		else $error("seal bit");
	a_adapter_lvl: assert property ($stable(adapter_detect_pin)[*4] ##0 reg_addr == 8'h05
		|-> reg_rdata[5] == !adapter_detect_pin) else $error("adapter bit");
	a_button_lvl: assert property ($stable(push_button_pin)[*4] ##0 reg_addr == 8'h05
		|-> reg_rdata[4] == !push_button_pin) else $error("button bit");
	a_pf_off: assert property (reg_addr == 8'h06 && !reg_rdata[1] && $stable(reg_rdata[1]) && $stable(reg_addr)
		|-> !powerfail_shutdown) else $error("shutdown while disabled");
	a_flag_clear: assert property (wake_from_off |=> reg_addr != 8'h07 || reg_rdata == 8'h00) else $error("flags");
	cover property (backup_cell_measure_go);
	cover property (powerfail_shutdown);
	cover property (wake_from_off ##1 reg_addr == 8'h07);
endmodule : pscf_regs_assertions
bind pscf_regs pscf_regs_assertions i_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
	.adapter_detect_pin, .push_button_pin, .seal_broken, .wake_from_off, .backup_cell_measure_go,
	.powerfail_shutdown);

// File: testbench.sv
/* self-checking bench of the register bank; assumes the cell model on the measurement side */
`timescale 1ns/1ps
module testbench;
	logic clk, rst_n, reg_wr, ad, pb, pf, seal, nvm, ws, wo, go, done, shut;
	logic [7:0] addr, wdata, rdata, rails;
	logic [1:0] lvl, res;
	pscf_pkg::pscf_seq_t seq;
	int error_cnt = 0, samples_checked = 0, seed = 32'h6CA7, cc = 0, i, r1, r2;
	pscf_regs i_pscf_regs (.clk, .rst_n, .reg_addr(addr), .reg_wr, .reg_wdata(wdata), .reg_rdata(rdata),
		.adapter_detect_pin(ad), .push_button_pin(pb), .powerfail_output_n(pf), .seal_broken(seal),
		.nvm_differs(nvm), .seq_state(seq), .rails_on(rails), .wake_from_suspend(ws), .wake_from_off(wo),
		.backup_cell_measure_go(go), .backup_cell_measure_done(done), .backup_cell_result(res),
		.powerfail_shutdown(shut));
	pscf_cell_model i_pscf_cell_model (.clk, .go, .level(lvl), .done, .result(res));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task end_of_test;
		if (error_cnt == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task cmp(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task chk(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		#1 cmp(rdata, e);
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		addr = a;
		wdata = d;
		reg_wr = 1'b1;
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr
	function logic [7:0] st;
		return {seal, nvm, ~ad, ~pb, seq, cc[1:0]};
	endfunction : st
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		{rst_n, reg_wr, ws, wo, seal, nvm} = 6'h00;
		{ad, pb, pf} = 3'h7;
		addr = 8'h00;
		wdata = 8'h00;
		rails = 8'hFF;
		lvl = 2'h0;
		seq = pscf_pkg::PSCF_SEQ_ACTIVE;
		cyc(8);
		rst_n = 1'b1;
		cyc(6);
		chk(8'h06, 8'h00);
		chk(8'h07, 8'h00);
		chk(8'h05, st());
		for (i = 0; i < 4; i++) begin
			lvl = i[1:0];
			wr(8'h06, 8'hFF);
			cmp({7'h00, go}, 8'h01);
			chk(8'h06, 8'h03);
			cyc(8);
			cc = i;
			chk(8'h06, 8'h02);
			chk(8'h05, st());
		end
		r1 = $random(seed);
		wr(8'h06, 8'hFE);
		wr(8'h05, r1[7:0]);
		wr(8'h07, r1[7:0]);
		wr(8'h09, r1[7:0]);
		chk(8'h06, 8'h02);
		chk(8'h07, 8'h00);
		chk(8'h09, 8'h00);
		pf = 1'b0;
		cyc(5);
		cmp({7'h00, shut}, 8'h01);
		wr(8'h06, 8'h00);
		cyc(3);
		cmp({7'h00, shut}, 8'h00);
		pf = 1'b1;
		for (i = 0; i < 8; i++) begin
			r1 = $random(seed);
			{seal, nvm, ad, pb} = r1[3:0];
			seq = pscf_pkg::pscf_seq_t'(i[1:0]);
			cyc(5);
			chk(8'h05, st());
		end
		for (i = 0; i < 3; i++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			rails = r1[7:0];
			cyc(3);
			rails = r2[7:0];
			cyc(3);
			ws = 1'b1;
			cyc(1);
			ws = 1'b0;
			chk(8'h07, r1[7:0] & r2[7:0]);
		end
		rails = 8'hFF;
		ws = 1'b1;
		cyc(1);
		ws = 1'b0;
		chk(8'h07, 8'hFF);
		wr(8'h06, 8'h02);
		rst_n = 1'b0;
		chk(8'h05, 8'h00);
		chk(8'h06, 8'h00);
		chk(8'h07, 8'h00);
		cyc(2);
		rst_n = 1'b1;
		cc = 0;
		cyc(6);
		chk(8'h05, st());
		ws = 1'b1;
		cyc(1);
		ws = 1'b0;
		chk(8'h07, 8'hFF);
		wo = 1'b1;
		cyc(1);
		wo = 1'b0;
		chk(8'h07, 8'h00);
		end_of_test();
	end
endmodule : testbench
